// [uart_pin_pkg.sv]
package uart_pin_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DEFAULT_BAUD = 9_600;
  // serial clock source runs at 16 ticks per bit
  localparam logic [15:0] DIVISOR_RESET = 16'(CLK_HZ / (DEFAULT_BAUD * 16));
  localparam logic [3:0] TICKS_PER_BIT = 4'hF;
  localparam logic [3:0] HALF_BIT = 4'h7;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned QUEUE_DEPTH = 16;
  localparam logic [4:0] RTS_HIGH_RESET = 5'h0C;
  localparam logic [4:0] RTS_LOW_RESET = 5'h04;

  // register indexes on the plain register port
  localparam logic [2:0] REG_CONTROL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_TX_DATA = 3'h2;
  localparam logic [2:0] REG_RX_DATA = 3'h3;
  localparam logic [2:0] REG_DIVISOR = 3'h4;
  localparam logic [2:0] REG_RTS_LEVEL = 3'h5;

  // control register fields
  localparam int unsigned CTL_TX_EN = 0;
  localparam int unsigned CTL_RX_EN = 1;
  localparam int unsigned CTL_LOOPBACK = 2;
  localparam int unsigned CTL_CTS_EN = 3;
  localparam int unsigned CTL_RTS_AUTO = 4;
  localparam int unsigned CTL_RTS_MANUAL = 5;
  localparam int unsigned CTL_STOP_CLK = 6;
  localparam int unsigned CTL_TWO_STOP = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_STOP
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic frame_err;
  } rx_word_s;

endpackage

// [uart_pin_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser for asynchronous pins
module uart_pin_sync (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic async_i,
  output logic sync_o
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_s;

  sync_state_s state;
  sync_state_s next_state;

  always_comb begin
    next_state.meta = async_i;
    next_state.stable = state.meta;
  end

  // idle-high line resets to mark so no false start is seen
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= 2'b11;
    end else begin
      state <= next_state;
    end
  end

  assign sync_o = state.stable;
endmodule

// [uart_pin_behaviour.sv]
`timescale 1ns/1ps
// How it works
// - transmit line held at mark when disabled, idle, or in local loopback
// - characters leave least significant bit first, line changes on falling serial tick
// - receiver assembles incoming bits least significant bit first
// - outside local loopback, a level change on receive line restarts a stopped port clock
// - with clear-to-send checking enabled, a new character starts only while clear-to-send grants permission
// - request-to-send driven from a manual control bit, or automatically from receive queue fill level
module uart_pin_behaviour (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [15:0] rdata_o,
  input wire logic serial_receive_line_i,
  input wire logic clear_to_send_input_n_i,
  output logic serial_transmit_line_o,
  output logic request_to_send_output_n_o
);

  localparam int unsigned QW = $clog2(uart_pin_pkg::QUEUE_DEPTH);

  typedef struct packed {
    logic [7:0] control;
    logic [15:0] divisor;
    logic [4:0] rts_high;
    logic [4:0] rts_low;
    logic [15:0] rdata;
    logic [15:0] div_cnt;
    logic serial_phase;
    logic clk_running;
    logic rx_prev;
    uart_pin_pkg::tx_state_e tx_state;
    logic [3:0] tx_tick;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic [7:0] tx_hold;
    logic tx_full;
    logic tx_stop2;
    logic txd;
    logic line_out;
    uart_pin_pkg::rx_state_e rx_state;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic [QW-1:0] wr_ptr;
    logic [QW-1:0] rd_ptr;
    logic [QW:0] count;
    logic overrun;
    logic rts_n;
  } core_state_s;

  core_state_s state;
  core_state_s next_state;
  uart_pin_pkg::rx_word_s queue [uart_pin_pkg::QUEUE_DEPTH];
  logic push;
  logic pop;
  logic rx_sync;
  logic cts_n_sync;
  logic rx_in;
  logic tick;
  uart_pin_pkg::rx_word_s push_word;

  uart_pin_sync rx_sync_inst (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(serial_receive_line_i),
    .sync_o(rx_sync)
  );

  uart_pin_sync cts_sync_inst (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(clear_to_send_input_n_i),
    .sync_o(cts_n_sync)
  );

  function automatic logic bit_set(input logic [7:0] ctl, input int unsigned pos);
    bit_set = ctl[pos];
  endfunction

  // loopback feeds the internal transmit stream back to the receiver
  assign rx_in = bit_set(state.control, uart_pin_pkg::CTL_LOOPBACK) ? state.txd : rx_sync;
  // both shifters advance on the falling half of the serial clock source
  assign tick = state.clk_running && state.div_cnt == 16'h0000 && state.serial_phase;
  assign pop = read_i && addr_i == uart_pin_pkg::REG_RX_DATA && state.count != '0;

  always_comb begin
    next_state = state;
    push = 1'b0;
    push_word = '0;

    // register port writes
    if (write_i) begin
      unique case (addr_i)
        uart_pin_pkg::REG_CONTROL: next_state.control = wdata_i[7:0];
        uart_pin_pkg::REG_TX_DATA: begin
          if (!state.tx_full) begin
            next_state.tx_hold = wdata_i[7:0];
            next_state.tx_full = 1'b1;
          end
        end
        uart_pin_pkg::REG_DIVISOR: next_state.divisor = wdata_i;
        uart_pin_pkg::REG_RTS_LEVEL: begin
          next_state.rts_high = wdata_i[4:0];
          next_state.rts_low = wdata_i[12:8];
        end
        default: begin
        end
      endcase
    end

    // read data stand in the cycle after the strobe only
    next_state.rdata = 16'h0000;
    if (read_i) begin
      unique case (addr_i)
        uart_pin_pkg::REG_CONTROL: next_state.rdata = {8'h00, state.control};
        uart_pin_pkg::REG_STATUS: next_state.rdata = {2'h0, state.count[QW:0] == '0, state.overrun,
          state.tx_state == uart_pin_pkg::TX_IDLE, state.tx_full, state.clk_running, cts_n_sync,
          3'h0, state.count};
        uart_pin_pkg::REG_RX_DATA: next_state.rdata = {7'h00, queue[state.rd_ptr].frame_err,
          queue[state.rd_ptr].data};
        uart_pin_pkg::REG_DIVISOR: next_state.rdata = state.divisor;
        uart_pin_pkg::REG_RTS_LEVEL: next_state.rdata = {3'h0, state.rts_low, 3'h0, state.rts_high};
        default: next_state.rdata = 16'h0000;
      endcase
    end
    if (read_i && addr_i == uart_pin_pkg::REG_STATUS) begin
      next_state.overrun = 1'b0;
    end

    // port clock gating and wake-up
    next_state.rx_prev = rx_in;
    // a low line keeps the clock up so a waking start bit is not lost
    if (bit_set(state.control, uart_pin_pkg::CTL_STOP_CLK) && state.tx_state == uart_pin_pkg::TX_IDLE
        && state.rx_state == uart_pin_pkg::RX_IDLE && !state.tx_full && rx_in) begin
      next_state.clk_running = 1'b0;
    end
    if (rx_in != state.rx_prev || !bit_set(state.control, uart_pin_pkg::CTL_STOP_CLK)) begin
      next_state.clk_running = 1'b1;
    end
    if (write_i && addr_i == uart_pin_pkg::REG_TX_DATA) begin
      next_state.clk_running = 1'b1;
    end

    // serial clock source: one phase per divisor period, two phases per tick
    if (state.clk_running) begin
      if (state.div_cnt == 16'h0000) begin
        next_state.div_cnt = state.divisor;
        next_state.serial_phase = !state.serial_phase;
      end else begin
        next_state.div_cnt = state.div_cnt - 16'h0001;
      end
    end

    // transmitter
    if (!bit_set(state.control, uart_pin_pkg::CTL_TX_EN)) begin
      next_state.tx_state = uart_pin_pkg::TX_IDLE;
    end else if (tick) begin
      unique case (state.tx_state)
        uart_pin_pkg::TX_IDLE: begin
          if (state.tx_full && (!bit_set(state.control, uart_pin_pkg::CTL_CTS_EN) || !cts_n_sync)) begin
            next_state.tx_state = uart_pin_pkg::TX_START;
            next_state.tx_shift = state.tx_hold;
            next_state.tx_full = 1'b0;
            next_state.tx_tick = uart_pin_pkg::TICKS_PER_BIT;
            next_state.tx_stop2 = bit_set(state.control, uart_pin_pkg::CTL_TWO_STOP);
          end
        end
        uart_pin_pkg::TX_START: begin
          next_state.tx_tick = state.tx_tick - 4'h1;
          if (state.tx_tick == 4'h0) begin
            next_state.tx_state = uart_pin_pkg::TX_DATA;
            next_state.tx_bit = 3'h0;
            next_state.tx_tick = uart_pin_pkg::TICKS_PER_BIT;
          end
        end
        uart_pin_pkg::TX_DATA: begin
          next_state.tx_tick = state.tx_tick - 4'h1;
          if (state.tx_tick == 4'h0) begin
            next_state.tx_shift = {1'b0, state.tx_shift[7:1]};
            next_state.tx_bit = state.tx_bit + 3'h1;
            next_state.tx_tick = uart_pin_pkg::TICKS_PER_BIT;
            if (state.tx_bit == 3'(uart_pin_pkg::DATA_BITS - 1)) begin
              next_state.tx_state = uart_pin_pkg::TX_STOP;
            end
          end
        end
        uart_pin_pkg::TX_STOP: begin
          next_state.tx_tick = state.tx_tick - 4'h1;
          if (state.tx_tick == 4'h0) begin
            next_state.tx_tick = uart_pin_pkg::TICKS_PER_BIT;
            if (state.tx_stop2) begin
              next_state.tx_stop2 = 1'b0;
            end else begin
              next_state.tx_state = uart_pin_pkg::TX_IDLE;
            end
          end
        end
      endcase
    end
    unique case (next_state.tx_state)
      uart_pin_pkg::TX_START: next_state.txd = 1'b0;
      uart_pin_pkg::TX_DATA: next_state.txd = next_state.tx_shift[0];
      default: next_state.txd = 1'b1;
    endcase
    // loopback keeps the outer line at mark
    next_state.line_out = next_state.txd | bit_set(next_state.control, uart_pin_pkg::CTL_LOOPBACK);

    // receiver, sampling mid-bit
    if (!bit_set(state.control, uart_pin_pkg::CTL_RX_EN)) begin
      next_state.rx_state = uart_pin_pkg::RX_IDLE;
    end else if (tick) begin
      unique case (state.rx_state)
        uart_pin_pkg::RX_IDLE: begin
          if (!rx_in) begin
            next_state.rx_state = uart_pin_pkg::RX_START;
            next_state.rx_tick = uart_pin_pkg::HALF_BIT;
          end
        end
        uart_pin_pkg::RX_START: begin
          next_state.rx_tick = state.rx_tick - 4'h1;
          if (state.rx_tick == 4'h0) begin
            // a glitch that is high again mid-bit is no start
            next_state.rx_state = rx_in ? uart_pin_pkg::RX_IDLE : uart_pin_pkg::RX_DATA;
            next_state.rx_bit = 3'h0;
            next_state.rx_tick = uart_pin_pkg::TICKS_PER_BIT;
          end
        end
        uart_pin_pkg::RX_DATA: begin
          next_state.rx_tick = state.rx_tick - 4'h1;
          if (state.rx_tick == 4'h0) begin
            next_state.rx_shift = {rx_in, state.rx_shift[7:1]};
            next_state.rx_bit = state.rx_bit + 3'h1;
            next_state.rx_tick = uart_pin_pkg::TICKS_PER_BIT;
            if (state.rx_bit == 3'(uart_pin_pkg::DATA_BITS - 1)) begin
              next_state.rx_state = uart_pin_pkg::RX_STOP;
            end
          end
        end
        uart_pin_pkg::RX_STOP: begin
          next_state.rx_tick = state.rx_tick - 4'h1;
          if (state.rx_tick == 4'h0) begin
            next_state.rx_state = uart_pin_pkg::RX_IDLE;
            push_word.data = state.rx_shift;
            push_word.frame_err = !rx_in;
            if (state.count == (QW+1)'(uart_pin_pkg::QUEUE_DEPTH) && !pop) begin
              next_state.overrun = 1'b1;
            end else begin
              push = 1'b1;
            end
          end
        end
      endcase
    end

    // receive queue pointers
    if (push) begin
      next_state.wr_ptr = state.wr_ptr + QW'(1);
    end
    if (pop) begin
      next_state.rd_ptr = state.rd_ptr + QW'(1);
    end
    next_state.count = state.count + (QW+1)'(push) - (QW+1)'(pop);

    // request-to-send: manual level, or hysteresis on queue fill
    if (bit_set(state.control, uart_pin_pkg::CTL_RTS_AUTO)) begin
      if (next_state.count >= state.rts_high) begin
        next_state.rts_n = 1'b1;
      end else if (next_state.count <= state.rts_low) begin
        next_state.rts_n = 1'b0;
      end
    end else begin
      next_state.rts_n = !bit_set(state.control, uart_pin_pkg::CTL_RTS_MANUAL);
    end
  end

  // queue storage is not reset; only pointers are
  always_ff @(posedge clk_i) begin
    if (push) begin
      queue[state.wr_ptr] <= push_word;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= '0;
      state.control <= uart_pin_pkg::CONTROL_RESET;
      state.divisor <= uart_pin_pkg::DIVISOR_RESET;
      state.rts_high <= uart_pin_pkg::RTS_HIGH_RESET;
      state.rts_low <= uart_pin_pkg::RTS_LOW_RESET;
      state.clk_running <= 1'b1;
      state.rx_prev <= 1'b1;
      state.txd <= 1'b1;
      state.line_out <= 1'b1;
      state.rts_n <= 1'b1;
      state.tx_state <= uart_pin_pkg::TX_IDLE;
      state.rx_state <= uart_pin_pkg::RX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_o = state.rdata;
  assign serial_transmit_line_o = state.line_out;
  assign request_to_send_output_n_o = state.rts_n;

endmodule

// [uart_pin_behaviour_checker.sv]
`timescale 1ns/1ps
module uart_pin_behaviour_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic [15:0] rdata_o,
  input wire logic serial_receive_line_i,
  input wire logic clear_to_send_input_n_i,
  input wire logic serial_transmit_line_o,
  input wire logic request_to_send_output_n_o
);
  logic [7:0] ctl;
  logic [8:0] high_cnt;
  wire tx = serial_transmit_line_o;
  wire rts_n = request_to_send_output_n_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // high run longer than a whole frame means no character is in flight
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl <= 8'h00;
      high_cnt <= 9'h000;
    end else begin
      if (write_i && addr_i == uart_pin_pkg::REG_CONTROL) begin
        ctl <= wdata_i[7:0];
      end
      high_cnt <= !tx ? 9'h000 : (high_cnt == 9'h1FF ? high_cnt : high_cnt + 9'h001);
    end
  end
  sequence long_idle;
    tx && high_cnt >= 9'h14A;
  endsequence
  reset_mark_a: assert property ($fell(sys_rst_i) |-> tx && rts_n) else $error("line not idle after reset");
  disabled_mark_a: assert property (!ctl[0] |-> tx) else $error("line low while disabled");
  loopback_mark_a: assert property (ctl[2] |-> tx) else $error("line low in loopback");
  bit_hold_a: assert property ($changed(tx) |=> $stable(tx) [*8]) else $error("bit too short");
  cts_hold_a: assert property (ctl[3] && clear_to_send_input_n_i && $past(clear_to_send_input_n_i, 4) ##0 long_idle
    |=> tx) else $error("start without permission");
  rts_manual_a: assert property (ctl[5] && !ctl[4] |-> ##[0:3] !rts_n) else $error("rts not asserted");
  rts_release_a: assert property (!ctl[5] && !ctl[4] |-> ##[0:3] rts_n) else $error("rts not negated");
  read_idle_a: assert property (!$past(read_i) |-> rdata_o == 16'h0000) else $error("read data outside slot");
  control_read_a: assert property (read_i && addr_i == uart_pin_pkg::REG_CONTROL |=> rdata_o[7:0] == ctl)
    else $error("control read mismatch");
endmodule

// [serial_peer.sv]
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_i,
  input wire logic line_from_dut_i,
  output logic line_to_dut_o,
  output logic cts_n_o
);
  logic [7:0] got;
  int got_count;
  initial begin
    line_to_dut_o = 1'b1;
    cts_n_o = 1'b0;
    got_count = 0;
  end
  task automatic set_hold(input logic v);
    cts_n_o <= v;
  endtask
  task automatic send_byte(input logic [7:0] b);
    line_to_dut_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      line_to_dut_o <= b[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    line_to_dut_o <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk_i);
  endtask
  // sample mid-bit; a frame only counts when its stop bit is high
  always begin
    @(negedge line_from_dut_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      got[i] = line_from_dut_i;
    end
    repeat (BIT_CLKS) @(posedge clk_i);
    if (line_from_dut_i) got_count++;
  end
endmodule

// [tb_uart_pin_behaviour.sv]
`timescale 1ns/1ps
module tb_uart_pin_behaviour;
  logic clk_i;
  logic sys_rst_i;
  logic [2:0] addr_i;
  logic [15:0] wdata_i;
  logic write_i;
  logic read_i;
  logic [15:0] rdata_o;
  logic rx_line, cts_n, tx_line, rts_n;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 clk_i = ~clk_i;
  uart_pin_behaviour uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .serial_receive_line_i(rx_line),
    .clear_to_send_input_n_i(cts_n), .serial_transmit_line_o(tx_line), .request_to_send_output_n_o(rts_n));
  serial_peer #(.BIT_CLKS(32)) peer (.clk_i(clk_i), .line_from_dut_i(tx_line), .line_to_dut_o(rx_line),
    .cts_n_o(cts_n));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // a spare edge after each access keeps strobes from being set twice in one step
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_cmp(input string what, input logic [2:0] a, input logic [15:0] exp);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clk_i);
    read_i <= 1'b0;
    #1 cmp(what, exp, rdata_o);
    @(posedge clk_i);
  endtask
  task automatic expect_tx(input logic [7:0] b, input int n);
    repeat (2000) begin
      if (peer.got_count >= n) break;
      @(posedge clk_i);
    end
    cmp("frames", 16'(n), 16'(peer.got_count));
    cmp("tx byte", {8'h00, b}, {8'h00, peer.got});
  endtask
  initial begin
    clk_i = 1'b0;
    sys_rst_i = 1'b1;
    addr_i = 3'h0;
    wdata_i = 16'h0000;
    write_i = 1'b0;
    read_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 cmp("tx in reset", 16'h0001, 16'(tx_line));
    cmp("rts in reset", 16'h0001, 16'(rts_n));
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd_cmp("control", uart_pin_pkg::REG_CONTROL, 16'h0000);
    rd_cmp("unmapped", 3'h7, 16'h0000);
    rd_cmp("divisor", uart_pin_pkg::REG_DIVISOR, uart_pin_pkg::DIVISOR_RESET);
    rd_cmp("rts levels", uart_pin_pkg::REG_RTS_LEVEL, 16'h040C);
    wr(uart_pin_pkg::REG_DIVISOR, 16'h0000);
    wr(uart_pin_pkg::REG_CONTROL, 16'h0003);
    wr(uart_pin_pkg::REG_TX_DATA, 16'h00A5);
    expect_tx(8'hA5, 1);
    $display("transmit test done");
    peer.send_byte(8'h3C);
    repeat (40) @(posedge clk_i);
    rd_cmp("rx data", uart_pin_pkg::REG_RX_DATA, 16'h003C);
    $display("receive test done");
    peer.set_hold(1'b1);
    wr(uart_pin_pkg::REG_CONTROL, 16'h000B);
    wr(uart_pin_pkg::REG_TX_DATA, 16'h0081);
    repeat (400) @(posedge clk_i);
    cmp("held frames", 16'h0001, 16'(peer.got_count));
    peer.set_hold(1'b0);
    expect_tx(8'h81, 2);
    $display("permission test done");
    wr(uart_pin_pkg::REG_CONTROL, 16'h0081);
    wr(uart_pin_pkg::REG_TX_DATA, 16'h00C3);
    expect_tx(8'hC3, 3);
    repeat (20) @(posedge clk_i);
    rd_cmp("second stop", uart_pin_pkg::REG_STATUS, 16'h2200);
    repeat (40) @(posedge clk_i);
    rd_cmp("stop done", uart_pin_pkg::REG_STATUS, 16'h2A00);
    $display("two stop test done");
    wr(uart_pin_pkg::REG_CONTROL, 16'h0007);
    wr(uart_pin_pkg::REG_TX_DATA, 16'h0000);
    repeat (400) @(posedge clk_i);
    cmp("loop frames", 16'h0003, 16'(peer.got_count));
    rd_cmp("loop data", uart_pin_pkg::REG_RX_DATA, 16'h0000);
    $display("loopback test done");
    wr(uart_pin_pkg::REG_CONTROL, 16'h0020);
    repeat (4) @(posedge clk_i);
    cmp("rts manual", 16'h0000, 16'(rts_n));
    wr(uart_pin_pkg::REG_RTS_LEVEL, 16'h0102);
    wr(uart_pin_pkg::REG_CONTROL, 16'h0013);
    peer.send_byte(8'h11);
    peer.send_byte(8'h22);
    repeat (40) @(posedge clk_i);
    cmp("rts full", 16'h0001, 16'(rts_n));
    rd_cmp("rx first", uart_pin_pkg::REG_RX_DATA, 16'h0011);
    repeat (4) @(posedge clk_i);
    cmp("rts drained", 16'h0000, 16'(rts_n));
    rd_cmp("rx second", uart_pin_pkg::REG_RX_DATA, 16'h0022);
    $display("rts test done");
    wr(uart_pin_pkg::REG_CONTROL, 16'h0042);
    repeat (40) @(posedge clk_i);
    rd_cmp("stopped status", uart_pin_pkg::REG_STATUS, 16'h2800);
    peer.send_byte(8'h5A);
    repeat (40) @(posedge clk_i);
    rd_cmp("wake data", uart_pin_pkg::REG_RX_DATA, 16'h005A);
    $display("wake test done");
    close_out();
  end
endmodule
bind uart_pin_behaviour uart_pin_behaviour_checker chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
  .serial_receive_line_i(serial_receive_line_i), .clear_to_send_input_n_i(clear_to_send_input_n_i),
  .serial_transmit_line_o(serial_transmit_line_o), .request_to_send_output_n_o(request_to_send_output_n_o));
